// [src/mtpl_pkg.sv]
package mtpl_pkg;

  // ***************************************************
  // transmitter word and tap geometry
  // ***************************************************
  localparam int TX_W     = 28;
  localparam int TAP_W    = 8;
  localparam int NTAP     = 10;
  localparam int TAPS_W   = TAP_W * NTAP;

  // ***************************************************
  // full 8-tap placement of the three ports per link
  // ***************************************************
  localparam int P1_TX [TAP_W] = '{0, 1, 2, 3, 4, 6, 27, 5};
  localparam int P2_TX [TAP_W] = '{7, 8, 9, 12, 13, 14, 10, 11};
  localparam int P3_TX [TAP_W] = '{15, 18, 19, 20, 21, 22, 16, 17};
  localparam int TX_SPARE = 23;
  localparam int TX_LVAL  = 24;
  localparam int TX_FVAL  = 25;
  localparam int TX_DVAL  = 26;

  // tap index of port one on links x, y, z (a, d, g)
  localparam int FULL_X_TAP = 0;
  localparam int FULL_Y_TAP = 3;
  localparam int FULL_Z_TAP = 6;

  // ***************************************************
  // 10-tap bit packing
  // ***************************************************
  localparam int TEN_X_BITS  = 24;
  localparam int TEN_X_TAIL  = 26;
  localparam int TEN_YZ_BITS = 27;
  localparam int TEN_Y_BASE  = 26;
  localparam int TEN_Z_BASE  = 53;

  // ***************************************************
  // buffer entry layout
  // ***************************************************
  localparam int ENT_LVAL = TAPS_W;
  localparam int ENT_FVAL = TAPS_W + 1;
  localparam int ENT_TEN  = TAPS_W + 2;
  localparam int ENT_W    = TAPS_W + 3;

  localparam logic [TX_W-1:0] TX_IDLE = 28'h0000000;

endpackage : mtpl_pkg

// [src/mtpl_buf.sv]
`timescale 1ns/1ns
module mtpl_buf #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);

  // ***************************************************
  // two-entry buffer, head register drives the output
  // ***************************************************
  logic [1:0]   count;
  logic [W-1:0] tail;
  logic         push;
  logic         pop;

  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= 2'h0;
    end else if (push && !pop) begin
      count <= count + 2'h1;
    end else if (pop && !push) begin
      count <= count - 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_data_o <= '0;
      tail       <= '0;
    end else begin
      // full buffer refuses pushes, so pop alone shifts tail up
      if (count == 2'h2 && pop) begin
        out_data_o <= tail;
      end else if (push && (count == 2'h0 || pop)) begin
        out_data_o <= in_data_i;
      end else if (push) begin
        tail <= in_data_i;
      end
    end
  end

endmodule : mtpl_buf

// [src/mtpl_mapper.sv]
`timescale 1ns/1ns
// Behaviour
// RQ1: full mode sends eight 8-bit taps a..h, bit 7 msb and bit 0 lsb.
// RQ2: every transmitter input without an assigned signal is driven low.
// RQ3: full mode routes a,b,c to link x, d,e,f to y, g,h to z, z port 3 idle.
// RQ4: full mode port bits use the fixed tx tables, lval 24, fval 25, dval 26.
// RQ5: 10-tap mode packs a..j in order over x,y,z with lval on y/z input 27.
// RQ6: the frame grabber supplies external sync over camera control line 1.
// RQ7: all taps and valids of one pixel reach the three links together.
module mtpl_mapper
  import mtpl_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  // camera pixel side
  input  wire logic             pix_valid_i,
  output logic                  pix_ready_o,
  input  wire logic             pix_ten_i,
  input  wire logic             pix_lval_i,
  input  wire logic             pix_fval_i,
  input  wire logic [TAP_W-1:0] tap_a_i,
  input  wire logic [TAP_W-1:0] tap_b_i,
  input  wire logic [TAP_W-1:0] tap_c_i,
  input  wire logic [TAP_W-1:0] tap_d_i,
  input  wire logic [TAP_W-1:0] tap_e_i,
  input  wire logic [TAP_W-1:0] tap_f_i,
  input  wire logic [TAP_W-1:0] tap_g_i,
  input  wire logic [TAP_W-1:0] tap_h_i,
  input  wire logic [TAP_W-1:0] tap_i_i,
  input  wire logic [TAP_W-1:0] tap_j_i,
  // transmitter side
  input  wire logic             link_clk_i,
  output logic      [TX_W-1:0]  tx_x_o,
  output logic      [TX_W-1:0]  tx_y_o,
  output logic      [TX_W-1:0]  tx_z_o,
  output logic                  tx_strobe_o,
  output logic                  tx_ten_o
);

  // ***************************************************
  // mapping of one buffered pixel onto three links
  // ***************************************************
  function automatic logic [3*TX_W-1:0] map_pixel(
    input logic [ENT_W-1:0] e
  );
    logic [TX_W-1:0] x;
    logic [TX_W-1:0] y;
    logic [TX_W-1:0] z;
    x = TX_IDLE; // RQ2
    y = TX_IDLE;
    z = TX_IDLE;
    if (e[ENT_TEN]) begin
      for (int k = 0; k < TEN_X_BITS; k++) begin
        x[k] = e[k]; // RQ5
      end
      x[TX_LVAL]    = e[ENT_LVAL];
      x[TX_FVAL]    = e[ENT_FVAL];
      x[TEN_X_TAIL] = e[TEN_X_BITS];
      x[TEN_YZ_BITS] = e[TEN_X_BITS+1];
      for (int k = 0; k < TEN_YZ_BITS; k++) begin
        y[k] = e[TEN_Y_BASE+k]; // RQ5
        z[k] = e[TEN_Z_BASE+k];
      end
      y[TEN_YZ_BITS] = e[ENT_LVAL];
      z[TEN_YZ_BITS] = e[ENT_LVAL];
    end else begin
      for (int b = 0; b < TAP_W; b++) begin
        x[P1_TX[b]] = e[(FULL_X_TAP  )*TAP_W+b]; // RQ1 RQ3 RQ4
        x[P2_TX[b]] = e[(FULL_X_TAP+1)*TAP_W+b];
        x[P3_TX[b]] = e[(FULL_X_TAP+2)*TAP_W+b];
        y[P1_TX[b]] = e[(FULL_Y_TAP  )*TAP_W+b];
        y[P2_TX[b]] = e[(FULL_Y_TAP+1)*TAP_W+b];
        y[P3_TX[b]] = e[(FULL_Y_TAP+2)*TAP_W+b];
        z[P1_TX[b]] = e[(FULL_Z_TAP  )*TAP_W+b];
        z[P2_TX[b]] = e[(FULL_Z_TAP+1)*TAP_W+b];
      end
      x[TX_LVAL] = e[ENT_LVAL]; // RQ4
      y[TX_LVAL] = e[ENT_LVAL];
      z[TX_LVAL] = e[ENT_LVAL];
      x[TX_FVAL] = e[ENT_FVAL];
      y[TX_FVAL] = e[ENT_FVAL];
      z[TX_FVAL] = e[ENT_FVAL];
      // data valid follows line valid on every link
      x[TX_DVAL] = e[ENT_LVAL];
      y[TX_DVAL] = e[ENT_LVAL];
      z[TX_DVAL] = e[ENT_LVAL];
    end
    return {z, y, x};
  endfunction : map_pixel

  // ***************************************************
  // pixel buffer
  // ***************************************************
  logic [ENT_W-1:0] buf_in;
  logic [ENT_W-1:0] buf_data;
  logic             buf_valid;
  logic             buf_pop;

  assign buf_in = {pix_ten_i, pix_fval_i, pix_lval_i,
                   tap_j_i, tap_i_i, tap_h_i, tap_g_i, tap_f_i,
                   tap_e_i, tap_d_i, tap_c_i, tap_b_i, tap_a_i};

  mtpl_buf #(
    .W (ENT_W)
  ) u_buf (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (pix_valid_i),
    .in_ready_o  (pix_ready_o),
    .in_data_i   (buf_in),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop),
    .out_data_o  (buf_data)
  );

  // ***************************************************
  // link clock sampling
  // ***************************************************
  logic link_s1;
  logic link_s2;
  logic link_s3;
  logic link_lvl;
  logic link_fall;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link_s1 <= 1'b0;
      link_s2 <= 1'b0;
      link_s3 <= 1'b0;
    end else begin
      link_s1 <= link_clk_i;
      link_s2 <= link_s1;
      link_s3 <= link_s2;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link_lvl <= 1'b0;
    end else if (link_s2 == link_s3) begin
      link_lvl <= link_s3;
    end
  end

  // words change on the falling edge, transmitters sample on the rising one
  assign link_fall = (link_s2 == link_s3) && !link_s3 && link_lvl;
  assign buf_pop   = link_fall;

  // ***************************************************
  // transmitter words, all three loaded in one cycle
  // ***************************************************
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_x_o      <= TX_IDLE;
      tx_y_o      <= TX_IDLE;
      tx_z_o      <= TX_IDLE;
      tx_ten_o    <= 1'b0;
      tx_strobe_o <= 1'b0;
    end else begin
      tx_strobe_o <= link_fall && buf_valid;
      if (link_fall && buf_valid) begin
        {tx_z_o, tx_y_o, tx_x_o} <= map_pixel(buf_data); // RQ7
        tx_ten_o <= buf_data[ENT_TEN];
      end else if (link_fall) begin
        // starved link: valids drop, no stale pixel repeats
        tx_x_o <= TX_IDLE; // RQ2
        tx_y_o <= TX_IDLE;
        tx_z_o <= TX_IDLE;
      end
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb_sys @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_pop_full;
    link_fall && buf_valid && !buf_data[ENT_TEN];
  endsequence

  sequence s_pop_ten;
    link_fall && buf_valid && buf_data[ENT_TEN];
  endsequence

  AST_FULL_MSB: assert property ( // RQ1
    s_pop_full |=> tx_x_o[P1_TX[TAP_W-1]] == $past(buf_data[TAP_W-1])
               && tx_x_o[P1_TX[0]] == $past(buf_data[0]))
    else $error("full mode tap a msb or lsb misplaced");

  AST_IDLE_LOW: assert property ( // RQ2
    link_fall && !buf_valid |=> tx_x_o == TX_IDLE && tx_y_o == TX_IDLE
                             && tx_z_o == TX_IDLE)
    else $error("starved link word not low");

  AST_FULL_UNUSED: assert property ( // RQ2
    tx_strobe_o && !tx_ten_o |-> !tx_z_o[P3_TX[0]] && !tx_z_o[P3_TX[TAP_W-1]]
                             && !tx_x_o[TX_SPARE] && !tx_z_o[TX_SPARE])
    else $error("unused full mode input not low");

  AST_FULL_ROUTE: assert property ( // RQ3
    s_pop_full |=> tx_y_o[P1_TX[0]] == $past(buf_data[FULL_Y_TAP*TAP_W])
               && tx_z_o[P2_TX[TAP_W-1]] ==
                  $past(buf_data[(FULL_Z_TAP+2)*TAP_W-1]))
    else $error("full mode tap routed to wrong link");

  AST_FULL_VALID: assert property ( // RQ4
    s_pop_full |=> tx_x_o[TX_DVAL] == $past(buf_data[ENT_LVAL])
               && tx_z_o[TX_FVAL] == $past(buf_data[ENT_FVAL])
               && tx_y_o[TX_LVAL] == tx_y_o[TX_DVAL])
    else $error("full mode valid bits misplaced");

  AST_TEN_PACK: assert property ( // RQ5
    s_pop_ten |=> tx_x_o[TEN_X_TAIL] == $past(buf_data[TEN_X_BITS])
              && tx_z_o[TEN_YZ_BITS] == $past(buf_data[ENT_LVAL])
              && tx_z_o[0] == $past(buf_data[TEN_Z_BASE]))
    else $error("ten tap packing wrong");

  AST_LOAD_TOGETHER: assert property ( // RQ7
    !link_fall |=> $stable(tx_x_o) && $stable(tx_y_o) && $stable(tx_z_o))
    else $error("link word changed away from a link edge");

  AST_STROBE_ONCE: assert property ( // RQ7
    tx_strobe_o |=> !tx_strobe_o [*2])
    else $error("more than one load per link period");

endmodule : mtpl_mapper

// [testbench/mtpl_grab.sv]
`timescale 1ns/1ns
module mtpl_grab
  import mtpl_pkg::*;
(
  // link clock toward the camera
  output logic                 link_clk_o,
  // external sync on camera control line one
  output logic                 cc1_sync_o,
  // transmitter inputs
  input  wire logic [TX_W-1:0] tx_x_i,
  input  wire logic [TX_W-1:0] tx_y_i,
  input  wire logic [TX_W-1:0] tx_z_i,
  // captured words
  output logic      [TX_W-1:0] cap_x_o,
  output logic      [TX_W-1:0] cap_y_o,
  output logic      [TX_W-1:0] cap_z_o,
  output logic      [15:0]     cap_n_o
);
  // one sync pulse, one link period wide, every 32 link periods
  always @(posedge link_clk_o) begin
    cc1_sync_o <= (cap_n_o[4:0] == 5'h00);
  end

  // free running, each edge a fixed 13 ns before a system clock rising edge
  initial begin
    link_clk_o = 1'b0;
    #7;
    forever #160 link_clk_o = ~link_clk_o;
  end

  // latched mid-word, away from the update instant
  always @(negedge link_clk_o) begin
    cap_x_o <= tx_x_i;
    cap_y_o <= tx_y_i;
    cap_z_o <= tx_z_i;
    cap_n_o <= cap_n_o + 16'h0001;
  end

  initial cap_n_o = 16'h0000;
endmodule : mtpl_grab

// [testbench/mtpl_mapper_tb.sv]
`timescale 1ns/1ns
module mtpl_mapper_tb
  import mtpl_pkg::*;
;
  // ****
  // signals
  // ****
  logic             sys_clk, sys_rst, vld, ten, lv, fv, saw_full;
  logic [TAP_W-1:0] tp [NTAP];
  logic             ready, strobe, tx_ten, link_clk, cc1;
  logic [TX_W-1:0]  tx_x, tx_y, tx_z, cap_x, cap_y, cap_z;
  logic [15:0]      cap_n;
  int               n_fail, compares;

  mtpl_mapper uut (
    .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .pix_valid_i(vld),
    .pix_ready_o(ready), .pix_ten_i(ten), .pix_lval_i(lv),
    .pix_fval_i(fv), .tap_a_i(tp[0]), .tap_b_i(tp[1]), .tap_c_i(tp[2]),
    .tap_d_i(tp[3]), .tap_e_i(tp[4]), .tap_f_i(tp[5]), .tap_g_i(tp[6]),
    .tap_h_i(tp[7]), .tap_i_i(tp[8]), .tap_j_i(tp[9]),
    .link_clk_i(link_clk), .tx_x_o(tx_x), .tx_y_o(tx_y), .tx_z_o(tx_z),
    .tx_strobe_o(strobe), .tx_ten_o(tx_ten));

  mtpl_grab grab (
    .link_clk_o(link_clk), .tx_x_i(tx_x), .tx_y_i(tx_y), .tx_z_i(tx_z),
    .cap_x_o(cap_x), .cap_y_o(cap_y), .cap_z_o(cap_z), .cap_n_o(cap_n),
    .cc1_sync_o(cc1));

  always #20 sys_clk = ~sys_clk;

  // ****
  // helpers
  // ****
  task finish_test;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task chk(input string nm, input logic [TX_W-1:0] e, s);
    compares++;
    if (e !== s) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task tmo(input string nm);
    n_fail++;
    $display("BAD %s expected event seen timeout", nm);
    finish_test();
  endtask : tmo

  function logic [TX_W-1:0] fw(input logic [7:0] a, b, c, input logic l, f);
    logic [TX_W-1:0] w;
    w = TX_IDLE;
    for (int i = 0; i < TAP_W; i++) begin
      w[P1_TX[i]] = a[i];
      w[P2_TX[i]] = b[i];
      w[P3_TX[i]] = c[i];
    end
    w[TX_LVAL] = l;
    w[TX_FVAL] = f;
    w[TX_DVAL] = l;
    return w;
  endfunction : fw

  function logic [3*TX_W-1:0] expw(input logic m, l, f, input logic [7:0] sd);
    logic [TAPS_W-1:0] s;
    for (int k = 0; k < NTAP; k++) s[k*TAP_W +: TAP_W] = sd + 8'(k * 37);
    if (m)
      return {l, s[79:53], l, s[52:26], s[25:24], f, l, s[23:0]};
    return {fw(s[55:48], s[63:56], 8'h00, l, f),
            fw(s[31:24], s[39:32], s[47:40], l, f),
            fw(s[7:0], s[15:8], s[23:16], l, f)};
  endfunction : expw

  // ready is read at the falling edge so the take decision is race free
  task push(input logic m, l, f, input logic [7:0] sd);
    logic r;
    int   k;
    @(posedge sys_clk);
    ten <= m;
    lv  <= l;
    fv  <= f;
    vld <= 1'b1;
    for (k = 0; k < NTAP; k++) tp[k] <= sd + 8'(k * 37);
    r = 1'b0;
    for (k = 0; k < 64 && !r; k++) begin
      @(negedge sys_clk);
      r = (ready === 1'b1);
      if (!r) saw_full = 1'b1;
      @(posedge sys_clk);
    end
    vld <= 1'b0;
    if (!r) tmo("ready");
  endtask : push

  // camera starts its frame on the grabber's external sync
  task wait_sync;
    int k;
    for (k = 0; k < 512 && cc1 !== 1'b1; k++) @(negedge sys_clk);
    if (cc1 !== 1'b1) tmo("sync");
  endtask : wait_sync

  task wait_cap;
    logic [15:0] n0;
    n0 = cap_n;
    for (int k = 0; k < 64 && cap_n == n0; k++) @(negedge sys_clk);
    if (cap_n == n0) tmo("capture");
  endtask : wait_cap

  task expect_pix(input logic m, l, f, input logic [7:0] sd);
    logic [3*TX_W-1:0] e;
    e = expw(m, l, f, sd);
    for (int k = 0; k < 64 && strobe !== 1'b1; k++) @(negedge sys_clk);
    if (strobe !== 1'b1) tmo("strobe");
    chk("tx_ten", TX_W'(m), TX_W'(tx_ten));
    wait_cap();
    chk("link_x", e[TX_W-1:0], cap_x);
    chk("link_y", e[2*TX_W-1:TX_W], cap_y);
    chk("link_z", e[3*TX_W-1:2*TX_W], cap_z);
  endtask : expect_pix

  // ****
  // scenarios
  // ****
  task t_reset;
    @(negedge sys_clk);
    chk("ready", TX_W'(1'b1), TX_W'(ready));
    chk("strobe", TX_W'(1'b0), TX_W'(strobe));
    chk("idle", TX_IDLE, tx_x | tx_y | tx_z);
    $display("test reset done");
  endtask : t_reset

  task t_modes;
    wait_sync();
    push(1'b0, 1'b1, 1'b1, 8'h01);
    expect_pix(1'b0, 1'b1, 1'b1, 8'h01);
    push(1'b0, 1'b0, 1'b1, 8'hF0);
    expect_pix(1'b0, 1'b0, 1'b1, 8'hF0);
    push(1'b1, 1'b1, 1'b1, 8'h5A);
    expect_pix(1'b1, 1'b1, 1'b1, 8'h5A);
    push(1'b1, 1'b0, 1'b1, 8'hC3);
    expect_pix(1'b1, 1'b0, 1'b1, 8'hC3);
    $display("test modes done");
  endtask : t_modes

  // camera outruns the link: buffer fills, then drains to idle words
  task t_burst;
    saw_full = 1'b0;
    fork
      begin
        push(1'b0, 1'b1, 1'b1, 8'h11);
        push(1'b1, 1'b1, 1'b1, 8'h22);
        push(1'b0, 1'b1, 1'b0, 8'h33);
        push(1'b1, 1'b0, 1'b0, 8'h44);
      end
      begin
        expect_pix(1'b0, 1'b1, 1'b1, 8'h11);
        expect_pix(1'b1, 1'b1, 1'b1, 8'h22);
        expect_pix(1'b0, 1'b1, 1'b0, 8'h33);
        expect_pix(1'b1, 1'b0, 1'b0, 8'h44);
      end
    join
    chk("ready_low", TX_W'(1'b1), TX_W'(saw_full));
    wait_cap();
    wait_cap();
    chk("drained", TX_IDLE, cap_x | cap_y | cap_z);
    $display("test burst done");
  endtask : t_burst

  initial begin
    sys_clk  = 1'b0;
    sys_rst  = 1'b1;
    vld      = 1'b0;
    ten      = 1'b0;
    lv       = 1'b0;
    fv       = 1'b0;
    saw_full = 1'b0;
    n_fail   = 0;
    compares = 0;
    for (int k = 0; k < NTAP; k++) tp[k] = 8'h00;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_modes();
    t_burst();
    finish_test();
  end
endmodule : mtpl_mapper_tb
